// ### core/usm_serial_core.sv
// mode select, receiver and receive status flags of the shared serial module
module usm_serial_core #(
    parameter int BAUD_DIV = usm_pkg::BAUD_DIV
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] reg_sel,       // register select
    input  wire logic       reg_wr,        // write strobe
    input  wire logic       reg_rd,        // read strobe
    input  wire logic [7:0] reg_wdata,     // write data
    output logic      [7:0] reg_rdata,     // read data, one cycle after strobe
    input  wire logic       rx_in,         // receive pin
    input  wire logic       rx_enable,     // receiver enable
    input  wire logic       parity_enable, // parity on
    input  wire logic       parity_odd,    // odd when high
    input  wire logic       nine_bit,      // nine-bit frames
    input  wire logic       tx_idle_in,    // transmitter idle
    input  wire logic       tx_empty_in,   // tx holding empty
    output logic            async_mode_active,
    output logic      [2:0] sync_mode_field,
    output logic            sync_module_enable,
    output logic      [1:0] two_wire_debounce_select,
    output logic            rx_bit8,       // ninth received bit
    output logic      [7:0] tx_data,       // last data written
    output logic            tx_load        // data write pulse
);
    logic [7:0] ctrl_q;      // control register
    logic [7:0] rx_data_q;   // receive data register
    logic       rx_bit8_q;   // ninth bit beside data
    logic [7:0] tx_data_q;   // transmit data
    logic [7:0] rdata_q;     // read return
    logic       perr_q, nf_q, ferr_q, oerr_q, rxav_q;
    logic       armed_q;     // status read seen
    logic       noise_acc_q; // noise seen in current frame
    logic [8:0] shift_q;     // frame shifter
    logic [3:0] ovs_q;       // tick within bit
    logic [3:0] nbits_q;     // bits received
    // next values, receiver state, and registered and gated mode signals
    logic [7:0]             ctrl_d;        // control next value
    logic [7:0]             rx_data_d;     // receive data next value
    logic                   rx_bit8_d;     // ninth bit next value
    logic [7:0]             tx_data_d;     // transmit data next value
    logic [7:0]             rdata_d;       // read return next value
    logic                   perr_d;        // parity flag next value
    logic                   nf_d;          // noise flag next value
    logic                   ferr_d;        // framing flag next value
    logic                   oerr_d;        // overrun flag next value
    logic                   rxav_d;        // data-available next value
    logic                   armed_d;       // clear sequence next value
    logic                   noise_acc_d;   // frame noise next value
    logic [8:0]             shift_d;       // shifter next value
    logic [3:0]             ovs_d;         // tick count next value
    logic [3:0]             nbits_d;       // bit count next value
    usm_pkg::usm_rx_state_t state_q;       // receiver state
    usm_pkg::usm_rx_state_t state_d;       // receiver next state
    logic                   async_q;       // async select, registered out
    logic [2:0]             mode_q;        // gated mode field
    logic                   en_q;          // gated sync enable
    logic [1:0]             deb_q;         // gated debounce select
    logic                   async_sel;     // async select bit of control
    logic [2:0]             mode_gated;    // mode field, zero in async mode
    logic                   en_gated;      // enable, zero in async mode
    logic [1:0]             deb_gated;     // debounce, zero in async mode

    // register port decode
    logic                   wr_ctrl;       // control write
    logic                   wr_data;       // data register write
    logic                   rd_status;     // status read
    logic                   rd_data;       // data register read
    logic                   data_acc;      // any data register access
    logic                   clr_errs;      // second step of clear sequence
    logic                   clr_rxav;      // data read after status read
    logic [7:0]             status_word;   // assembled status
    logic [7:0]             rd_mux;        // selected read value

    assign wr_ctrl   = reg_wr && (reg_sel == usm_pkg::SEL_CTRL);
    assign wr_data   = reg_wr && (reg_sel == usm_pkg::SEL_DATA);
    // status writes decode to nothing, so software cannot touch a flag
    assign rd_status = reg_rd && (reg_sel == usm_pkg::SEL_STATUS); // [R5]
    assign rd_data   = reg_rd && (reg_sel == usm_pkg::SEL_DATA);
    assign data_acc  = wr_data || rd_data;
    assign clr_errs  = armed_q && data_acc; // [R8]
    assign clr_rxav  = armed_q && rd_data;  // [R8] [R13]

    // receiver helpers
    logic                   rx_on;         // receiver allowed to run
    logic                   tick;          // oversample tick
    logic                   restart;       // realign tick at start edge
    logic                   smp;           // take a vote sample
    logic                   bit_clr;       // reset the voter
    logic                   bit_eval;      // bit decision point
    logic                   vote;          // majority of the samples
    logic                   disagree;      // samples disagreed
    logic [3:0]             frame_len;     // bits after start, parity included
    logic                   last_bit;      // bit being decided is the last
    logic                   stop_eval;     // stop bit decided
    logic                   parity_bad;    // parity mismatch on frame
    logic [7:0]             frame_data;    // data byte of the frame
    logic                   frame_bit8;    // ninth bit of the frame
    logic                   xfer;          // frame lands in data register
    logic                   ovr_evt;       // frame lost to overrun

    // the receiver only runs in async mode
    assign rx_on      = ctrl_q[usm_pkg::CTRL_ASYNC] && rx_enable; // [R1]
    assign restart    = (state_q == usm_pkg::RX_IDLE) && rx_on && !rx_in;
    // three votes around mid-bit
    assign smp        = tick && (ovs_q >= usm_pkg::SMP_FIRST)
                        && (ovs_q <= usm_pkg::SMP_LAST); // [R16]
    assign bit_eval   = tick && (ovs_q == usm_pkg::STOP_DONE);
    assign bit_clr    = restart || (tick && (ovs_q == usm_pkg::OVS_LAST));
    // parity takes the ninth position when enabled
    assign frame_len  = (nine_bit || parity_enable) ? usm_pkg::BITS_9 : usm_pkg::BITS_8;
    assign last_bit   = ((nbits_q + 4'h1) == frame_len);
    assign stop_eval  = bit_eval && (state_q == usm_pkg::RX_STOP);
    assign frame_data = (frame_len == usm_pkg::BITS_9) ? shift_q[7:0] : shift_q[8:1];
    assign frame_bit8 = (frame_len == usm_pkg::BITS_9) && shift_q[8];
    // no parity means no parity error, whatever the line carried
    assign parity_bad = parity_enable && (parity_odd ? !(^shift_q) : (^shift_q)); // [R6] [R7]
    // single data register: a full one or a standing overrun blocks the move
    assign xfer       = stop_eval && !rxav_q && !oerr_q; // [R13] [R14]
    assign ovr_evt    = stop_eval && (rxav_q || oerr_q); // [R14]

    // oversample tick, realigned on each start edge
    usm_tick #(
        .DIV      (BAUD_DIV)
    ) u_tick (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .restart  (restart),
        .tick     (tick)
    );

    // majority voter for the bit under way
    usm_vote u_vote (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clr      (bit_clr),
        .smp      (smp),
        .bit_in   (rx_in),
        .vote     (vote),
        .disagree (disagree) // [R16]
    );

    // status word, one flag per position
    assign status_word[usm_pkg::ST_PERR]  = perr_q;
    assign status_word[usm_pkg::ST_NF]    = nf_q;
    assign status_word[usm_pkg::ST_FERR]  = ferr_q;
    assign status_word[usm_pkg::ST_OERR]  = oerr_q;
    assign status_word[usm_pkg::ST_RIDLE] = (state_q == usm_pkg::RX_IDLE);
    assign status_word[usm_pkg::ST_RXAV]  = rxav_q;
    assign status_word[usm_pkg::ST_TIDLE] = tx_idle_in;
    assign status_word[usm_pkg::ST_TXE]   = tx_empty_in;

    // read selection
    assign rd_mux = (reg_sel == usm_pkg::SEL_CTRL)   ? ctrl_q :
                    (reg_sel == usm_pkg::SEL_STATUS) ? status_word :
                    (reg_sel == usm_pkg::SEL_DATA)   ? rx_data_q : 8'h00;

    // mode fields only act while the async select is low
    assign async_sel  = ctrl_q[usm_pkg::CTRL_ASYNC]; // [R1]
    assign mode_gated = async_sel ? 3'h0 : ctrl_q[usm_pkg::CTRL_MODE_HI:usm_pkg::CTRL_MODE_LO]; // [R2]
    assign en_gated   = !async_sel && ctrl_q[usm_pkg::CTRL_EN]; // [R4]
    assign deb_gated  = async_sel ? 2'h0 : ctrl_q[usm_pkg::CTRL_DEB_HI:usm_pkg::CTRL_DEB_LO];

    // register port next values
    assign ctrl_d    = wr_ctrl ? reg_wdata : ctrl_q;
    assign tx_data_d = wr_data ? reg_wdata : tx_data_q;
    assign rdata_d   = reg_rd ? rd_mux : rdata_q;
    assign armed_d   = rd_status ? 1'b1 : (data_acc ? 1'b0 : armed_q);

    // flags: a new event wins over a clear in the same cycle
    assign perr_d    = (xfer && parity_bad) ? 1'b1 : (clr_errs ? 1'b0 : perr_q); // [R6]
    assign nf_d      = (xfer && (noise_acc_q || disagree)) ? 1'b1 :
                       (clr_errs ? 1'b0 : nf_q); // [R9] [R10] [R11]
    assign ferr_d    = (xfer && !vote) ? 1'b1 : (clr_errs ? 1'b0 : ferr_q); // [R12] [R15]
    assign oerr_d    = ovr_evt ? 1'b1 : (clr_errs ? 1'b0 : oerr_q); // [R14]
    assign rxav_d    = xfer ? 1'b1 : (clr_rxav ? 1'b0 : rxav_q); // [R13]
    assign rx_data_d = xfer ? frame_data : rx_data_q;
    assign rx_bit8_d = xfer ? frame_bit8 : rx_bit8_q;

    // receiver sequencing
    always_comb begin
        state_d     = state_q;
        ovs_d       = ovs_q;
        nbits_d     = nbits_q;
        shift_d     = shift_q;
        noise_acc_d = noise_acc_q;
        if (tick) begin
            ovs_d = ovs_q + 4'h1;
        end
        case (state_q)
            usm_pkg::RX_IDLE: begin
                // hold counts at zero until a start edge
                ovs_d   = 4'h0;
                nbits_d = 4'h0;
                if (restart) begin
                    state_d     = usm_pkg::RX_START;
                    shift_d     = 9'h000;
                    noise_acc_d = 1'b0;
                end
            end
            usm_pkg::RX_START: begin
                // a high vote at mid start bit is a false start
                if (bit_eval) begin
                    noise_acc_d = disagree; // [R9]
                    state_d     = vote ? usm_pkg::RX_IDLE : usm_pkg::RX_DATA;
                end
            end
            usm_pkg::RX_DATA: begin
                // shift in lsb first
                if (bit_eval) begin
                    shift_d     = {vote, shift_q[8:1]};
                    nbits_d     = nbits_q + 4'h1;
                    noise_acc_d = noise_acc_q || disagree; // [R9]
                    if (last_bit) begin
                        state_d = usm_pkg::RX_STOP;
                    end
                end
            end
            usm_pkg::RX_STOP: begin
                // flags are taken from the stop decision
                if (bit_eval) begin
                    state_d = usm_pkg::RX_IDLE;
                end
            end
            default: begin
                state_d = usm_pkg::RX_IDLE;
            end
        endcase
        if (!rx_on) begin
            state_d = usm_pkg::RX_IDLE;
        end
    end

    // register port state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_q    <= usm_pkg::CTRL_RESET;
            tx_data_q <= 8'h00;
            rdata_q   <= 8'h00;
            armed_q   <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            tx_data_q <= tx_data_d;
            rdata_q   <= rdata_d;
            armed_q   <= armed_d;
        end
    end

    // registered mode outputs
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            async_q <= 1'b0;
            mode_q  <= usm_pkg::CTRL_RESET[usm_pkg::CTRL_MODE_HI:usm_pkg::CTRL_MODE_LO];
            en_q    <= 1'b0;
            deb_q   <= 2'h0;
        end else begin
            async_q <= async_sel;
            mode_q  <= mode_gated;
            en_q    <= en_gated;
            deb_q   <= deb_gated;
        end
    end

    // status flags
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            perr_q <= 1'b0;
            nf_q   <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
            rxav_q <= 1'b0;
        end else begin
            perr_q <= perr_d;
            nf_q   <= nf_d;
            ferr_q <= ferr_d;
            oerr_q <= oerr_d;
            rxav_q <= rxav_d;
        end
    end

    // receiver registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_q     <= usm_pkg::RX_IDLE;
            ovs_q       <= 4'h0;
            nbits_q     <= 4'h0;
            shift_q     <= 9'h000;
            noise_acc_q <= 1'b0;
            rx_data_q   <= 8'h00;
            rx_bit8_q   <= 1'b0;
        end else begin
            state_q     <= state_d;
            ovs_q       <= ovs_d;
            nbits_q     <= nbits_d;
            shift_q     <= shift_d;
            noise_acc_q <= noise_acc_d;
            rx_data_q   <= rx_data_d;
            rx_bit8_q   <= rx_bit8_d;
        end
    end

    // outputs
    assign reg_rdata                = rdata_q;
    assign async_mode_active        = async_q;
    assign sync_mode_field          = mode_q;
    assign sync_module_enable       = en_q;
    assign two_wire_debounce_select = deb_q;
    assign rx_bit8                  = rx_bit8_q;
    assign tx_data                  = tx_data_q;
    assign tx_load                  = wr_data;

    // control writes are stored whole
    property p_ctrl_write;
        @(posedge core_clk) disable iff (!reset_n)
        wr_ctrl |=> (ctrl_q == $past(reg_wdata));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // [R1]

    // async mode hides the mode field
    property p_mode_gate;
        @(posedge core_clk) disable iff (!reset_n)
        async_sel |=> (sync_mode_field == 3'h0);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("mode field live in async mode"); // [R2]

    // async mode hides the sync enable
    property p_enable_gate;
        @(posedge core_clk) disable iff (!reset_n)
        async_sel |=> !sync_module_enable;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("sync enable live in async"); // [R4]

    // a status write leaves every flag alone
    property p_status_ro;
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && (reg_sel == usm_pkg::SEL_STATUS) && !stop_eval)
            |=> $stable({perr_q, nf_q, ferr_q, oerr_q, rxav_q});
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write changed a flag"); // [R5]

    // parity off never raises the parity flag
    property p_no_parity;
        @(posedge core_clk) disable iff (!reset_n)
        (xfer && !parity_enable && !perr_q) |=> !perr_q;
    endproperty
    a_no_parity: assert property (p_no_parity) else $error("parity flag with parity off"); // [R7]

    // noise rises only together with data-available
    property p_noise_with_rxav;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(nf_q) |-> $rose(rxav_q);
    endproperty
    a_noise_with_rxav: assert property (p_noise_with_rxav) else $error("noise flag alone"); // [R10]

    // an overrun frame leaves the noise flag as it was
    property p_overrun_noise;
        @(posedge core_clk) disable iff (!reset_n)
        (ovr_evt && !clr_errs) |=> (nf_q == $past(nf_q));
    endproperty
    a_overrun_noise: assert property (p_overrun_noise) else $error("overrun moved noise"); // [R11]

    // low stop vote on a transferred frame raises the framing flag
    property p_ferr;
        @(posedge core_clk) disable iff (!reset_n)
        (xfer && !vote) |=> ferr_q;
    endproperty
    a_ferr: assert property (p_ferr) else $error("framing error missed"); // [R15]

    // clear sequence: status read armed, then a data access
    sequence s_clear_step;
        clr_errs && !stop_eval;
    endsequence
    sequence s_errors_gone;
        !perr_q && !nf_q && !ferr_q && !oerr_q;
    endsequence
    property p_clear_seq;
        @(posedge core_clk) disable iff (!reset_n)
        s_clear_step |=> s_errors_gone;
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("error flags not cleared"); // [R8]
endmodule : usm_serial_core

// ### core/usm_pkg.sv
// Overview of operation
// R1: select bit high means async serial mode
// R2: mode field 7..5 acts only when select low
// R3: software keeps select low for sync modes
// R4: sync enable bit 1 acts only select low
// R5: status register flags ignore software writes
// R6: parity mismatch sets parity flag bit 7
// R7: parity flag never set when parity off
// R8: status read then data access clears errors
// R9: majority-sample disagreement sets noise flag bit 6
// R10: noise flag sets with data-available flag
// R11: overrun character leaves noise flag unchanged
// R12: framing error sets framing flag bit 5
// R13: data-available flag tracks data register contents
// R14: overrun flag set, blocks further transfers
// R15: low first stop bit is framing error
// R16: three mid-bit samples, disagreement means noise
package usm_pkg;
    // register select codes on the register port
    localparam logic [1:0] SEL_CTRL   = 2'h0;
    localparam logic [1:0] SEL_STATUS = 2'h1;
    localparam logic [1:0] SEL_DATA   = 2'h2;
    // control register fields and reset value
    localparam int         CTRL_MODE_HI = 7;
    localparam int         CTRL_MODE_LO = 5;
    localparam int         CTRL_ASYNC   = 4;
    localparam int         CTRL_DEB_HI  = 3;
    localparam int         CTRL_DEB_LO  = 2;
    localparam int         CTRL_EN      = 1;
    localparam logic [7:0] CTRL_RESET   = 8'hE0;
    // status register bit positions
    localparam int         ST_PERR  = 7;
    localparam int         ST_NF    = 6;
    localparam int         ST_FERR  = 5;
    localparam int         ST_OERR  = 4;
    localparam int         ST_RIDLE = 3;
    localparam int         ST_RXAV  = 2;
    localparam int         ST_TIDLE = 1;
    localparam int         ST_TXE   = 0;
    // oversampling: sixteen ticks per bit, votes on ticks 7..9
    localparam int         OVS_N     = 16;
    localparam logic [3:0] SMP_FIRST = 4'h7;
    localparam logic [3:0] SMP_LAST  = 4'h9;
    localparam logic [3:0] STOP_DONE = 4'hA;
    localparam logic [3:0] OVS_LAST  = 4'hF;
    localparam logic [3:0] BITS_8    = 4'h8;
    localparam logic [3:0] BITS_9    = 4'h9;
    // clock and default line rate
    localparam int         CLK_HZ   = 20_000_000;
    localparam int         BAUD_HZ  = 9600;
    localparam int         BAUD_DIV = CLK_HZ / (BAUD_HZ * OVS_N);
    // receiver states
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } usm_rx_state_t;
endpackage : usm_pkg

// ### core/usm_tick.sv
// oversample tick generator: one pulse every DIV clocks
module usm_tick #(
    parameter int DIV = 130
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic restart,  // realign the tick phase
    output logic      tick      // one-cycle pulse
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;  // divider count
    logic [CW-1:0] cnt_d;

    assign tick  = (cnt_q == LAST);
    assign cnt_d = (restart || tick) ? '0 : cnt_q + CW'(1);

    // divider register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : usm_tick

// ### core/usm_vote.sv
// three-sample majority voter with disagreement detect
module usm_vote (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clr,       // start a new bit
    input  wire logic smp,       // take one sample
    input  wire logic bit_in,    // line level
    output logic      vote,      // majority of samples
    output logic      disagree   // samples not all equal
);
    logic [1:0] ones_q;  // count of high samples
    logic [1:0] cnt_q;   // samples taken

    // majority and noise from the counters
    assign vote     = (ones_q >= 2'h2);
    assign disagree = (cnt_q != 2'h0) && (ones_q != 2'h0) && (ones_q != cnt_q); // [R16]

    // sample accumulation
    always_ff @(posedge core_clk) begin
        if (!reset_n || clr) begin
            ones_q <= 2'h0;
            cnt_q  <= 2'h0;
        end else if (smp) begin
            ones_q <= ones_q + {1'b0, bit_in};
            cnt_q  <= cnt_q + 2'h1;
        end
    end
endmodule : usm_vote

// ### testbench/usm_rx_partner.sv
// far-end serial sender: drives frames onto the receive pin
module usm_rx_partner #(parameter int BIT_CLKS = 64) (
    input  wire logic core_clk,
    output logic      rx_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rx_in = 1'b1; // idle line high
    // shifts frame bits out lsb first, one bit per BIT_CLKS clocks
    // g names a bit that gets a short mid-bit glitch, -1 for none
    task automatic send(input logic [11:0] frame, input int n, input int g);
        for (int i = 0; i < n; i++) begin
            rx_in = frame[i];
            if (i == g) begin
                repeat (35) @(negedge core_clk);
                rx_in = ~frame[i];
                repeat (4) @(negedge core_clk);
                rx_in = frame[i];
                repeat (BIT_CLKS - 39) @(negedge core_clk);
            end else begin
                repeat (BIT_CLKS) @(negedge core_clk);
            end
        end
        rx_in = 1'b1; // back to idle
    endtask : send
endmodule : usm_rx_partner

// ### testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 4;         // short bit time: 64 clocks
    logic        core_clk, reset_n, reg_wr, reg_rd, rx_in, am, en;
    logic        par_en = 0, par_odd = 0, rb8, txl;
    logic [1:0]  db;
    logic [7:0]  txd;
    int          load_cnt = 0;
    logic [1:0]  reg_sel = 0;
    logic [2:0]  mf;
    logic [7:0]  reg_wdata = 0, reg_rdata, rd, d;
    logic [31:0] lfsr = 32'hd846;   // fixed seed
    int          mismatches = 0, cmp_count = 0;
    usm_rx_partner #(.BIT_CLKS(DIV * 16)) rx (.core_clk(core_clk), .rx_in(rx_in));
    usm_serial_core #(.BAUD_DIV(DIV)) dut (.core_clk(core_clk), .reset_n(reset_n),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rx_in(rx_in), .rx_enable(1'b1), .parity_enable(par_en),
        .parity_odd(par_odd), .nine_bit(1'b0), .tx_idle_in(1'b1), .tx_empty_in(1'b1),
        .async_mode_active(am), .sync_mode_field(mf), .sync_module_enable(en),
        .two_wire_debounce_select(db), .rx_bit8(rb8), .tx_data(txd), .tx_load(txl));
    // counts data write pulses
    always @(posedge core_clk) if (txl === 1'b1) load_cnt++;
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    // one register access; read data lands one cycle after the strobe
    task automatic acc(input logic [1:0] s, input logic w, input logic [7:0] v);
        @(negedge core_clk);
        {reg_sel, reg_wr, reg_rd, reg_wdata} = {s, w, !w, v};
        @(negedge core_clk);
        rd = reg_rdata;
        {reg_wr, reg_rd} = 2'b00;
    endtask : acc
    // sends one frame, then checks status, data and the cleared status
    task automatic frame(input logic [11:0] f, input int n, input int g, input logic [7:0] st);
        rx.send(f, n, g);
        repeat (128) @(negedge core_clk);
        acc(usm_pkg::SEL_STATUS, 0, 0);
        cmp("status", st, rd);
        acc(usm_pkg::SEL_DATA, 0, 0);
        cmp("data", d, rd);
        acc(usm_pkg::SEL_STATUS, 0, 0);
        cmp("cleared", 8'h0B, rd);
    endtask : frame
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    initial begin
        core_clk = 0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        {reset_n, reg_wr, reg_rd} = 3'b000;
        repeat (10) @(negedge core_clk);
        reset_n = 1;
        acc(usm_pkg::SEL_CTRL, 0, 0);
        cmp("ctrl reset", usm_pkg::CTRL_RESET, rd);
        acc(usm_pkg::SEL_STATUS, 1, 8'hF4);
        acc(usm_pkg::SEL_STATUS, 0, 0);
        cmp("status ro", 8'h0B, rd);
        repeat (6) begin
            lfsr = nxt(lfsr);
            acc(usm_pkg::SEL_CTRL, 1, lfsr[7:0]);
            acc(usm_pkg::SEL_CTRL, 0, 0);
            cmp("ctrl", lfsr[7:0] & 8'hFE, rd & 8'hFE);
            cmp("async", {7'h0, lfsr[4]}, {7'h0, am});
            cmp("enable", {7'h0, lfsr[1] & !lfsr[4]}, {7'h0, en});
            cmp("mode", {5'h0, lfsr[4] ? 3'h0 : lfsr[7:5]}, {5'h0, mf});
            cmp("debounce", {6'h0, lfsr[4] ? 2'h0 : lfsr[3:2]}, {6'h0, db});
        end
        acc(usm_pkg::SEL_CTRL, 1, 8'h10);
        lfsr = nxt(lfsr);
        d = lfsr[7:0];
        frame({2'b00, 1'b0, d, 1'b0}, 10, -1, 8'h2F);
        lfsr = nxt(lfsr);
        d = lfsr[7:0];
        frame({2'b11, 1'b1, d, 1'b0}, 10, 3, 8'h4F);
        rx.send({2'b11, 1'b1, d, 1'b0}, 10, -1);
        repeat (128) @(negedge core_clk);
        frame({2'b11, 1'b1, ~d, 1'b0}, 10, 5, 8'h1F);
        par_en = 1;
        d = 8'hC3;
        frame({1'b1, ~(^d), d, 1'b0}, 11, -1, 8'h8F);
        cmp("rx bit8", 8'h01, {7'h0, rb8});
        par_odd = 1;
        d = 8'h3C;
        frame({1'b1, ~(^d), d, 1'b0}, 11, -1, 8'h0F);
        acc(usm_pkg::SEL_DATA, 1, 8'h5A);
        cmp("tx data", 8'h5A, txd);
        cmp("tx loads", 8'h01, load_cnt[7:0]);
        finish_test();
    end
endmodule : testbench
